// >>> design/clock_divider_regs.vh
`ifndef CLOCK_DIVIDER_REGS_VH
`define CLOCK_DIVIDER_REGS_VH

// Register byte offsets
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// Control register fields
`define CTRL_HOLD_BIT 0
`define CTRL_RESET_VALUE 32'h00000000

// Status register fields
`define STAT_READY_BIT 0
`define STAT_RESET_BIT 1
`define STAT_MODE_BIT 2
`define STAT_SOURCE_BIT 3
`define STAT_CPU_CLOCK_BIT 4
`define STAT_PERIPH_CLOCK_BIT 5
`define STAT_HOLD_BIT 6
`define STAT_COUNT_LSB 8

// Divide-by-three counter
`define DIV_LAST 2'h2
`define DIV_HIGH 2'h0
`define DIV_INIT 2'h2

// Synchroniser pin bundle positions
`define PIN_CRYSTAL 0
`define PIN_EXT_FREQ 1
`define PIN_STRAP 2
`define PIN_MODE_N 3
`define PIN_CLEAR 4
`define PIN_READY_FIRST 5
`define PIN_READY_SECOND 6
`define PIN_QUAL1_N 7
`define PIN_QUAL2_N 8
`define PIN_RESET_REQ_N 9
`define PIN_COUNT 10

`endif

// >>> design/pin_synchroniser.v
`default_nettype none
module pin_synchroniser #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);
    // First stage feeds only the second, to let metastability settle
    reg [WIDTH-1:0] meta;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {WIDTH{1'b0}};
            q_o <= {WIDTH{1'b0}};
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> design/clock_divider_ready_reset_sync.v
// The Wishbone slave port and the address map were chosen for this implementation.
`include "clock_divider_regs.vh"
`default_nettype none
module clock_divider_ready_reset_sync (
    input wire clk_i,
    input wire rst_i,
    // Classic Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Clock sources and strap
    input wire crystal_pin_a_i,
    output reg crystal_pin_b_o,
    input wire external_frequency_in_i,
    input wire source_select_i,
    input wire counter_clear_in_i,
    // Ready inputs
    input wire bus_ready_first_i,
    input wire bus_ready_second_i,
    input wire bus_qualifier_first_n_i,
    input wire bus_qualifier_second_n_i,
    input wire sync_mode_select_n_i,
    // Reset request
    input wire reset_request_n_i,
    // Generated outputs
    output reg cpu_clock_o,
    output reg peripheral_clock_o,
    output reg oscillator_out_o,
    output reg ready_o,
    output reg reset_o
);
    wire [`PIN_COUNT-1:0] pins_raw;
    wire [`PIN_COUNT-1:0] pins;

    reg ctrl_hold;
    reg source_sel;
    reg strap_taken;
    reg strap_settle_a;
    reg strap_settle_b;
    reg crystal_prev;
    reg ext_freq_prev;
    reg [1:0] div_count;
    reg ready_stage_one;
    reg mode_seen;

    wire src_tick;
    wire hold;
    wire cpu_rise;
    wire cpu_fall;
    wire qualified_ready;
    wire bus_req;
    reg [1:0] next_count;
    reg next_stage_two;
    reg [31:0] next_dat;

    // Divider state test, shared by the counter and both clock enables
    function count_is;
        input [1:0] count;
        input [1:0] state;
        begin
            count_is = (count == state);
        end
    endfunction

    // A bus-ready input counts only while its own qualifier is low
    function qualify;
        input ready;
        input enable_n;
        begin
            qualify = ready & ~enable_n;
        end
    endfunction

    assign pins_raw[`PIN_CRYSTAL] = crystal_pin_a_i;
    assign pins_raw[`PIN_EXT_FREQ] = external_frequency_in_i;
    assign pins_raw[`PIN_STRAP] = source_select_i;
    assign pins_raw[`PIN_MODE_N] = sync_mode_select_n_i;
    assign pins_raw[`PIN_CLEAR] = counter_clear_in_i;
    assign pins_raw[`PIN_READY_FIRST] = bus_ready_first_i;
    assign pins_raw[`PIN_READY_SECOND] = bus_ready_second_i;
    assign pins_raw[`PIN_QUAL1_N] = bus_qualifier_first_n_i;
    assign pins_raw[`PIN_QUAL2_N] = bus_qualifier_second_n_i;
    assign pins_raw[`PIN_RESET_REQ_N] = reset_request_n_i;

    // All pins come from outside this clock domain
    pin_synchroniser #(
        .WIDTH(`PIN_COUNT)
    ) u_pins (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins)
    );

    // Strap is caught once the synchroniser has refilled after reset;
    // its reset value would otherwise always pick the crystal
    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_settle_a <= 1'b0;
            strap_settle_b <= 1'b0;
            strap_taken <= 1'b0;
            source_sel <= 1'b0;
        end else begin
            strap_settle_a <= 1'b1;
            strap_settle_b <= strap_settle_a;
            if (strap_settle_b && !strap_taken) begin
                strap_taken <= 1'b1;
                source_sel <= pins[`PIN_STRAP];
            end
        end
    end

    // Oscillator buffer and feedback drive, free of the strap
    always @(posedge clk_i) begin
        if (rst_i) begin
            oscillator_out_o <= 1'b0;
            crystal_pin_b_o <= 1'b1;
            crystal_prev <= 1'b0;
            ext_freq_prev <= 1'b0;
        end else begin
            oscillator_out_o <= pins[`PIN_CRYSTAL];
            crystal_pin_b_o <= ~pins[`PIN_CRYSTAL];
            crystal_prev <= pins[`PIN_CRYSTAL];
            ext_freq_prev <= pins[`PIN_EXT_FREQ];
        end
    end

    // Rising source edges become one-cycle enables; the source must be well
    // below half of clk_i or edges are missed
    // No tick before the strap is known, so no stray count slips in
    assign src_tick = strap_taken & (source_sel ?
        (pins[`PIN_EXT_FREQ] & ~ext_freq_prev) :
        (pins[`PIN_CRYSTAL] & ~crystal_prev));

    assign hold = pins[`PIN_CLEAR] | ctrl_hold;

    always @* begin
        next_count = div_count;
        if (hold) begin
            next_count = `DIV_INIT;
        end else if (src_tick) begin
            if (count_is(div_count, `DIV_LAST)) begin
                next_count = 2'h0;
            end else begin
                next_count = div_count + 2'h1;
            end
        end
    end

    // Processor clock edges as enables
    assign cpu_rise = ~hold & src_tick & count_is(div_count, `DIV_LAST);
    assign cpu_fall = ~hold & src_tick & count_is(div_count, `DIV_HIGH);

    always @(posedge clk_i) begin
        if (rst_i) begin
            div_count <= `DIV_INIT;
            cpu_clock_o <= 1'b0;
            peripheral_clock_o <= 1'b0;
        end else begin
            div_count <= next_count;
            cpu_clock_o <= count_is(next_count, `DIV_HIGH);
            if (hold) begin
                peripheral_clock_o <= 1'b0;
            end else if (cpu_fall) begin
                peripheral_clock_o <= ~peripheral_clock_o;
            end
        end
    end

    assign qualified_ready =
        qualify(pins[`PIN_READY_FIRST], pins[`PIN_QUAL1_N]) |
        qualify(pins[`PIN_READY_SECOND], pins[`PIN_QUAL2_N]);

    // Mode pin is read live at each falling edge
    always @* begin
        if (pins[`PIN_MODE_N]) begin
            next_stage_two = qualified_ready;
        end else begin
            next_stage_two = qualified_ready & ready_stage_one;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ready_stage_one <= 1'b0;
            ready_o <= 1'b0;
            reset_o <= 1'b1;
            mode_seen <= 1'b0;
        end else begin
            if (cpu_rise) begin
                ready_stage_one <= qualified_ready;
            end
            // Falls only on a processor falling edge, giving full hold
            if (cpu_fall) begin
                ready_o <= next_stage_two;
                mode_seen <= pins[`PIN_MODE_N];
                reset_o <= ~pins[`PIN_RESET_REQ_N];
            end
        end
    end

    // Register bus: one wait cycle, answer held one cycle
    assign bus_req = cyc_i & stb_i;

    always @* begin
        next_dat = 32'h00000000;
        case (adr_i)
            `CTRL_OFFSET: begin
                next_dat[`CTRL_HOLD_BIT] = ctrl_hold;
            end
            `STATUS_OFFSET: begin
                next_dat[`STAT_READY_BIT] = ready_o;
                next_dat[`STAT_RESET_BIT] = reset_o;
                next_dat[`STAT_MODE_BIT] = mode_seen;
                next_dat[`STAT_SOURCE_BIT] = source_sel;
                next_dat[`STAT_CPU_CLOCK_BIT] = cpu_clock_o;
                next_dat[`STAT_PERIPH_CLOCK_BIT] = peripheral_clock_o;
                next_dat[`STAT_HOLD_BIT] = hold;
                next_dat[`STAT_COUNT_LSB+1:`STAT_COUNT_LSB] = div_count;
            end
            default: begin
                next_dat = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            ctrl_hold <= 1'b0;
        end else begin
            ack_o <= bus_req & ~ack_o;
            if (bus_req & ~ack_o) begin
                dat_o <= next_dat;
            end
            // Write lands on the edge at which the master sees ack
            if (bus_req & ack_o & we_i & sel_i[0] &&
                adr_i == `CTRL_OFFSET) begin
                ctrl_hold <= dat_i[`CTRL_HOLD_BIT];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/clock_divider_asserts.sv
`default_nettype none
module clock_divider_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic crystal_pin_b_o,
    input wire logic counter_clear_in_i,
    input wire logic bus_ready_first_i,
    input wire logic bus_ready_second_i,
    input wire logic bus_qualifier_first_n_i,
    input wire logic bus_qualifier_second_n_i,
    input wire logic sync_mode_select_n_i,
    input wire logic reset_request_n_i,
    input wire logic cpu_clock_o,
    input wire logic peripheral_clock_o,
    input wire logic oscillator_out_o,
    input wire logic ready_o,
    input wire logic reset_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire qual = (bus_ready_first_i & ~bus_qualifier_first_n_i) |
        (bus_ready_second_i & ~bus_qualifier_second_n_i);
    AST_PCLK_ON_FALL: assert property (
        $rose(peripheral_clock_o) |-> $fell(cpu_clock_o))
        else $error("peripheral clock rose off a cpu fall");
    AST_READY_ON_FALL: assert property (
        $changed(ready_o) |-> $fell(cpu_clock_o))
        else $error("ready moved off a cpu fall");
    AST_RESET_ON_FALL: assert property (
        $changed(reset_o) |-> $fell(cpu_clock_o))
        else $error("reset moved off a cpu fall");
    // Inputs pass two sync flops, so they must settle before the fall
    AST_RESET_FOLLOW: assert property (
        $stable(reset_request_n_i) [*4] ##0 $fell(cpu_clock_o)
        |-> reset_o != reset_request_n_i)
        else $error("reset does not follow request");
    AST_READY_FOLLOW: assert property (
        $stable({qual, sync_mode_select_n_i}) [*4] ##0 $fell(cpu_clock_o)
        ##0 (sync_mode_select_n_i || !qual) |-> ready_o == qual)
        else $error("ready differs from qualified input");
    AST_HOLD: assert property (
        counter_clear_in_i [*4] |-> !cpu_clock_o && !peripheral_clock_o)
        else $error("clocks run during hold");
    // Six cycles match the partner's source period
    AST_CPU_DUTY: assert property (
        $rose(cpu_clock_o) |-> cpu_clock_o [*6] ##1 !cpu_clock_o [*8])
        else $error("cpu clock duty wrong");
    AST_XTAL_FB: assert property (
        crystal_pin_b_o != oscillator_out_o)
        else $error("crystal drive not inverse");
    cover property ($rose(ready_o) && !sync_mode_select_n_i);
    cover property ($fell(reset_o));
    cover property (counter_clear_in_i [*4] ##1 !counter_clear_in_i);
endmodule
`default_nettype wire

// >>> sim/clock_source_model.sv
`default_nettype none
module clock_source_model (
    input wire logic clk_i,
    input wire logic ext_run_i,
    output logic crystal_o,
    output logic ext_freq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt = 2'h0;
    initial begin
        crystal_o = 1'b0;
        ext_freq_o = 1'b0;
    end
    // Levels of three cycles so the synchroniser never drops an edge
    always @(posedge clk_i) begin
        cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
        if (cnt == 2'h2) begin
            crystal_o <= ~crystal_o;
            ext_freq_o <= ext_run_i ? ~ext_freq_o : ext_freq_o;
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_clock_divider_ready_reset_sync.sv
`include "clock_divider_regs.vh"
`default_nettype none
module test_clock_divider_ready_reset_sync;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00, ua;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, e, m;
    logic ack_o, crystal_pin_a_i, crystal_pin_b_o, external_frequency_in_i;
    logic source_select_i = 1'b0, counter_clear_in_i = 1'b0, ext_run = 1'b0;
    logic bus_ready_first_i = 1'b0, bus_ready_second_i = 1'b0;
    logic bus_qualifier_first_n_i = 1'b0, bus_qualifier_second_n_i = 1'b1;
    logic sync_mode_select_n_i = 1'b1, reset_request_n_i = 1'b0, sel;
    logic cpu_clock_o, peripheral_clock_o, oscillator_out_o, ready_o, reset_o;
    logic [31:0] exp_q[$], msk_q[$];
    int error_cnt = 0, cmp_count = 0, n;

    clock_divider_ready_reset_sync i_dut (.*);
    clock_source_model i_src (
        .clk_i(clk_i),
        .ext_run_i(ext_run),
        .crystal_o(crystal_pin_a_i),
        .ext_freq_o(external_frequency_in_i)
    );

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            cmp_count++;
            if ((dat_o & m) !== e) begin
                error_cnt++;
                $display("ERROR %0t got %h exp %h", $time, dat_o & m, e);
            end
        end
    end

    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic give_up();
        error_cnt++;
        report_and_stop();
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] mk, input logic [31:0] ex);
        if (!w) begin
            exp_q.push_back(ex);
            msk_q.push_back(mk);
        end
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            give_up();
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Returns just after the cpu clock has reached lvl from the other level
    task automatic wait_cpu(input logic lvl);
        for (n = 0; n < 100 && cpu_clock_o !== ~lvl; n++)
            @(posedge clk_i);
        while (n < 200 && cpu_clock_o !== lvl) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200)
            give_up();
    endtask

    initial begin
        void'($urandom(32'h2173c7f8));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `CTRL_OFFSET, 0, '1, `CTRL_RESET_VALUE);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h4A, 32'h2);
        ua = 8'h08 + 8'($urandom_range(0, 200));
        wb(1'b1, ua, '1, '1, 0);
        wb(1'b0, ua, 0, '1, 0);
        reset_request_n_i <= 1'b1;
        wait_cpu(1'b0);
        wait_cpu(1'b0);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h2, 0);
        for (int md = 1; md >= 0; md--) begin
            sel = 1'($urandom_range(0, 1));
            sync_mode_select_n_i <= md[0];
            wait_cpu(1'b1);
            bus_ready_first_i <= !sel;
            bus_ready_second_i <= sel;
            bus_qualifier_first_n_i <= sel;
            bus_qualifier_second_n_i <= !sel;
            wait_cpu(1'b0);
            wb(1'b0, `STATUS_OFFSET, 0, 32'h1, {31'h0, md[0]});
            wait_cpu(1'b0);
            wb(1'b0, `STATUS_OFFSET, 0, 32'h1, 32'h1);
            bus_ready_first_i <= sel;
            bus_ready_second_i <= !sel;
            wait_cpu(1'b0);
            wb(1'b0, `STATUS_OFFSET, 0, 32'h1, 0);
        end
        bus_qualifier_first_n_i <= 1'b0;
        bus_qualifier_second_n_i <= 1'b0;
        bus_ready_first_i <= 1'b0;
        bus_ready_second_i <= 1'b1;
        wait_cpu(1'b0);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h1, 32'h1);
        counter_clear_in_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h370, {22'h0, `DIV_INIT, 8'h40});
        wb(1'b1, `CTRL_OFFSET, 32'h1, '1, 0);
        counter_clear_in_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b0, `CTRL_OFFSET, 0, '1, 32'h1);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h370, {22'h0, `DIV_INIT, 8'h40});
        wb(1'b1, `CTRL_OFFSET, 0, '1, 0);
        wait_cpu(1'b0);
        rst_i <= 1'b1;
        source_select_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h318, 32'h208);
        ext_run <= 1'b1;
        wait_cpu(1'b0);
        wb(1'b0, `STATUS_OFFSET, 0, 32'h338, 32'h128);
        report_and_stop();
    end
endmodule

bind clock_divider_ready_reset_sync clock_divider_asserts i_chk (.*);
`default_nettype wire
